// *** hw/vsw_top.sv ***
// Control logic of the component video switch selector
`timescale 1ns/1ps
`include "vsw_map.svh"
module vsw_top
	import vsw_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Mode and bank pins
	input wire logic interface_mode_select_in,
	input wire logic bank_sel_in,
	// Two-wire link
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Analogue switch enables
	output logic [2:0] luma_chroma_on_out,
	output logic [1:0] rgbf_set_on_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pins_sync; // Inverted mode, bank, clock, data after two flops
	logic mode_s; // High selects direct pin control
	logic bank_s; // Bank / address select level
	logic scl_s; // Link clock level
	logic sda_s; // Link data level

	// The synchroniser resets every stage high, the idle bus level. The mode
	// pin goes through inverted, so that reset reads as serial mode: a raw
	// high would show direct code seven for two cycles and switch channels
	// on straight after reset.
	vsw_sync #(
		.WIDTH(4)
	) vsw_sync_inst (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.async_in({~interface_mode_select_in, bank_sel_in, scl_in, sda_in}),
		.sync_out(pins_sync)
	);

	// Undo the inversion; reset state is serial mode with switches off
	assign mode_s = !pins_sync[3]; // R16
	assign bank_s = pins_sync[2];
	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	vsw_top_s r_reg; // All registered state
	vsw_top_s r_next; // Its next value

	logic scl_rise; // Link clock rising edge
	logic scl_fall; // Link clock falling edge
	logic bus_start_event; // Data falls while clock high
	logic bus_stop_event; // Data rises while clock high
	logic [7:0] byte_in; // Byte including the bit now sampled
	logic addr_match; // Address byte is ours and a write
	logic byte_done; // Last bit of a data byte taken this cycle
	logic [4:0] byte_cfg; // Used field of the byte now completing

	// Edge and condition detection on synchronised levels
	assign scl_rise = scl_s && !r_reg.scl_d;
	assign scl_fall = !scl_s && r_reg.scl_d;
	assign bus_start_event = scl_s && r_reg.scl_d && r_reg.sda_d && !sda_s;
	assign bus_stop_event = scl_s && r_reg.scl_d && !r_reg.sda_d && sda_s;
	assign byte_in = {r_reg.shift[6:0], sda_s}; // R7

	// Bit zero of the address is the inverted bank level
	assign addr_match = (byte_in[7:3] == `VSW_ADDR_HI) // R23
		&& (byte_in[2] == `VSW_ADDR_A1) // R5
		&& (byte_in[1] == !bank_s) // R3 R4
		&& (byte_in[0] == `VSW_RW_WRITE); // R10 R11

	// Commit point of a data byte, used by the checks below only.
	// Start, stop and direct mode all win over a byte in flight.
	assign byte_done = !mode_s && !bus_start_event && !bus_stop_event
		&& (r_reg.state == VSW_DATA) && scl_rise
		&& (r_reg.bitcnt == `VSW_BYTE_BITS - 4'h1);
	assign byte_cfg = byte_in[`VSW_CFG_RGBF_MSB:`VSW_CFG_LC_LSB];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.scl_d = scl_s;
		r_next.sda_d = sda_s;
		if (mode_s) begin
			// Direct mode: link pins are plain inputs, receiver parked
			r_next.state = VSW_IDLE; // R1 R2
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (bus_start_event) begin
			// Start or repeated start always restarts with an address
			r_next.state = VSW_ADDR; // R8
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (bus_stop_event) begin
			// Partial byte dropped, configuration untouched
			r_next.state = VSW_IDLE; // R14
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else begin
			unique case (r_reg.state)
				VSW_IDLE, VSW_IGNORE: begin
					// Wait for a start; foreign traffic is ignored
					r_next.sda_oe = 1'b0; // R24
				end
				VSW_ADDR, VSW_DATA: begin
					// Shift in eight bits, MSB first
					if (scl_rise) begin
						r_next.shift = byte_in; // R7
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
						if (r_reg.bitcnt == `VSW_BYTE_BITS - 4'h1) begin
							if (r_reg.state == VSW_DATA) begin
								// Whole byte in: switches follow it
								r_next.cfg = byte_in[`VSW_CFG_RGBF_MSB:0]; // R13 R23
								r_next.state = VSW_ACK; // R12
							end else if (addr_match) begin
								r_next.state = VSW_ACK; // R9
							end else begin
								r_next.state = VSW_IGNORE; // R24 R11
							end
						end
					end
				end
				VSW_ACK: begin
					// Pull data low from eighth fall to ninth fall
					if (scl_fall) begin
						if (r_reg.bitcnt == `VSW_BYTE_BITS) begin
							r_next.sda_oe = 1'b1; // R9 R12
							r_next.bitcnt = `VSW_ACK_BIT;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.bitcnt = 4'h0;
							r_next.state = VSW_DATA; // R9 R13
						end
					end
				end
				default: begin
					// Illegal code recovers to idle
					r_next.state = VSW_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end

		// Switch outputs: stored byte or direct decode
		if (mode_s) begin
			// Direct decode follows pins each cycle
			unique case ({bank_s, sda_s, scl_s})
				3'h0: begin
					r_next.lc = `VSW_LC_OFF; // R22
					r_next.rgbf = `VSW_RGBF_OFF;
				end
				3'h1: begin
					r_next.lc = 3'h1; // R22
					r_next.rgbf = `VSW_RGBF_OFF;
				end
				3'h2: begin
					r_next.lc = 3'h2; // R22
					r_next.rgbf = `VSW_RGBF_OFF;
				end
				3'h3: begin
					r_next.lc = 3'h4; // R22
					r_next.rgbf = `VSW_RGBF_OFF;
				end
				3'h4: begin
					r_next.lc = `VSW_LC_OFF; // R22
					r_next.rgbf = 2'h1;
				end
				3'h5: begin
					r_next.lc = `VSW_LC_OFF; // R22
					r_next.rgbf = 2'h2;
				end
				3'h6: begin
					r_next.lc = 3'h2; // R22
					r_next.rgbf = 2'h1;
				end
				3'h7: begin
					r_next.lc = 3'h4; // R22
					r_next.rgbf = 2'h2;
				end
			endcase // R17
		end else begin
			// Serial mode holds the last stored byte
			r_next.lc = r_next.cfg[`VSW_CFG_LC_MSB:`VSW_CFG_LC_LSB]; // R18 R15
			r_next.rgbf = r_next.cfg[`VSW_CFG_RGBF_MSB:`VSW_CFG_RGBF_LSB]; // R19
		end

		// Clock enable low freezes everything
		if (!ce_in) begin
			r_next = r_reg;
		end
	end

	// ----------------------------------------------------------------
	// Register; reset leaves every switch off
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			r_reg <= '{
				scl_d: 1'b1,
				sda_d: 1'b1,
				state: VSW_IDLE,
				bitcnt: 4'h0,
				shift: 8'h00,
				cfg: `VSW_CFG_RESET, // R16
				sda_oe: 1'b0,
				lc: `VSW_LC_OFF,
				rgbf: `VSW_RGBF_OFF
			};
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only ever drives low; never a transmitter of data
	assign sda_out = 1'b0; // R11
	assign sda_oe_out = r_reg.sda_oe;
	assign luma_chroma_on_out = r_reg.lc;
	assign rgbf_set_on_out = r_reg.rgbf;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in || !ce_in);

	AST_DIRECT_NO_DRIVE: assert property (mode_s |=> !sda_oe_out) // R2
		else $error("Data line driven in direct mode");
	AST_DIRECT_OFF: assert property (mode_s && ({bank_s, sda_s, scl_s} == 3'h0)
		|=> (luma_chroma_on_out == 3'h0) && (rgbf_set_on_out == 2'h0)) // R22
		else $error("Direct code zero not all off");
	AST_DIRECT_SET2: assert property (mode_s && ({bank_s, sda_s, scl_s} == 3'h7)
		|=> (luma_chroma_on_out == 3'h4) && (rgbf_set_on_out == 2'h2)) // R17
		else $error("Direct code seven wrong");
	AST_NO_ACK_MISMATCH: assert property (r_reg.state == VSW_IGNORE
		|-> !sda_oe_out) // R24
		else $error("Acknowledge on foreign address");
	AST_ACK_AFTER_MATCH: assert property (!mode_s && r_reg.state == VSW_ADDR && scl_rise
		&& r_reg.bitcnt == 4'h7 && addr_match && !bus_start_event && !bus_stop_event
		|=> r_reg.state == VSW_ACK) // R9
		else $error("Matched address not acknowledged");
	AST_READ_IGNORED: assert property (!mode_s && r_reg.state == VSW_ADDR && scl_rise
		&& r_reg.bitcnt == 4'h7 && sda_s && !bus_start_event && !bus_stop_event
		|=> r_reg.state == VSW_IGNORE) // R10
		else $error("Read request not ignored");
	AST_ACK_ONLY_IN_ACK: assert property (sda_oe_out |-> r_reg.state == VSW_ACK
		&& r_reg.bitcnt == `VSW_ACK_BIT) // R12
		else $error("Data line driven outside acknowledge");
	AST_STOP_KEEPS: assert property (!mode_s && bus_stop_event
		|=> $stable(r_reg.cfg) ##1 $stable(luma_chroma_on_out)) // R14
		else $error("Stop changed configuration");
	AST_SERIAL_FOLLOWS_CFG: assert property (!mode_s && !$past(mode_s)
		|-> {rgbf_set_on_out, luma_chroma_on_out} == r_reg.cfg) // R18
		else $error("Switches differ from stored byte");

	// ----------------------------------------------------------------
	// Byte commit and framing checks
	// ----------------------------------------------------------------
	// Stored byte may only move on a complete data byte
	AST_CFG_ONLY_ON_BYTE: assert property (!$stable(r_reg.cfg)
		|-> $past(byte_done)) // R13
		else $error("Configuration changed without a whole byte");
	// Bits 0..4 of a whole byte land unchanged in the stored configuration
	AST_BYTE_COMMIT: assert property (byte_done
		|=> r_reg.cfg == $past(byte_cfg)) // R13
		else $error("Completed byte not stored");
	// Start always opens a fresh address byte, line released
	AST_START_ADDR: assert property (!mode_s && bus_start_event
		|=> (r_reg.state == VSW_ADDR) && !sda_oe_out) // R8
		else $error("Start did not open an address byte");
	// Stop parks the receiver whatever it was doing
	AST_STOP_IDLE: assert property (!mode_s && bus_stop_event
		|=> r_reg.state == VSW_IDLE) // R14
		else $error("Stop did not park the receiver");
	// Line released after the ninth pulse, next byte expected
	AST_ACK_RELEASE: assert property (!mode_s && !bus_start_event && !bus_stop_event
		&& (r_reg.state == VSW_ACK) && (r_reg.bitcnt == `VSW_ACK_BIT) && scl_fall
		|=> !sda_oe_out && (r_reg.state == VSW_DATA)) // R12
		else $error("Acknowledge not released after ninth pulse");
	AST_RESET_OFF: assert property (@(posedge mclk_in) disable iff (1'b0)
		$past(srst_in) |-> (luma_chroma_on_out == 3'h0) && (rgbf_set_on_out == 2'h0)) // R16
		else $error("Switches on after reset");

	COV_ADDR_ACK: cover property (r_reg.state == VSW_ACK && sda_oe_out);
	COV_DATA_BYTE: cover property (r_reg.state == VSW_DATA ##[1:1000]
		r_reg.state == VSW_ACK);
	COV_IGNORE: cover property (r_reg.state == VSW_IGNORE);
	COV_DIRECT: cover property (mode_s && rgbf_set_on_out != 2'h0);
	// Stop in the middle of a data byte
	COV_PARTIAL: cover property (bus_stop_event && r_reg.state == VSW_DATA
		&& r_reg.bitcnt != 4'h0);

endmodule : vsw_top

// *** hw/vsw_map.svh ***
// Address, field and reset constants of the video switch selector control
//
// Functional notes
// [R1] Mode pin low serial slave, high direct
// [R2] Direct mode: data, clock pins are static inputs
// [R3] Address bit zero is inverse of bank pin
// [R4] Four addresses, two chosen by bank pin
// [R5] Address bit one fixed at zero
// [R6] Master leaves both lines high when idle
// [R7] Eight bits MSB first, then acknowledge
// [R8] First byte after start is address
// [R9] Match acknowledged low on ninth pulse
// [R10] Eighth address bit is read/write, write only
// [R11] Never transmit; read requests are ignored
// [R12] Every data byte acknowledged on ninth pulse
// [R13] Each data byte updates the switches
// [R14] Stop keeps last complete byte, drops partial
// [R15] Switches hold their last configuration
// [R16] Serial mode reset turns every switch off
// [R17] Direct mode follows current control input levels
// [R18] Bits 0..2 enable luma/chroma pairs 0..2
// [R19] Bits 3..4 enable colour sets 1..2
// [R20] Master clock at most 100 kHz; the bench master clocks at 2.5 MHz
// [R21] Master bus free and start hold times
// [R22] Direct mode truth table from three pins
// [R23] Upper address fixed; byte bits 5..7 ignored
// [R24] Wrong address not acknowledged, bytes ignored
`ifndef VSW_MAP_SVH
`define VSW_MAP_SVH

// ----------------------------------------------------------------
// Device address
// ----------------------------------------------------------------
`define VSW_ADDR_HI 5'h0a
`define VSW_ADDR_A1 1'b0
`define VSW_RW_WRITE 1'b0

// ----------------------------------------------------------------
// Configuration byte fields and reset values
// ----------------------------------------------------------------
`define VSW_CFG_LC_LSB 0
`define VSW_CFG_LC_MSB 2
`define VSW_CFG_RGBF_LSB 3
`define VSW_CFG_RGBF_MSB 4
`define VSW_CFG_RESET 5'h00
`define VSW_LC_OFF 3'h0
`define VSW_RGBF_OFF 2'h0

// ----------------------------------------------------------------
// Bit counts on the serial link
// ----------------------------------------------------------------
`define VSW_BYTE_BITS 4'h8
`define VSW_ACK_BIT 4'h9

// ----------------------------------------------------------------
// Master timing, bench reference only
// ----------------------------------------------------------------
`define VSW_CLK_NS 50
`define VSW_TLOW_NS 4700
`define VSW_THIGH_NS 4000
`define VSW_TLOW_CYC ((`VSW_TLOW_NS + `VSW_CLK_NS - 1) / `VSW_CLK_NS)
`define VSW_THIGH_CYC ((`VSW_THIGH_NS + `VSW_CLK_NS - 1) / `VSW_CLK_NS)

`endif

// *** hw/vsw_pkg.sv ***
// Types of the video switch selector control
package vsw_pkg;

	// Serial receiver states
	typedef enum logic [2:0] {
		VSW_IDLE,
		VSW_ADDR,
		VSW_DATA,
		VSW_ACK,
		VSW_IGNORE
	} vsw_state_e;

	// Complete state of the top module
	typedef struct packed {
		logic scl_d;
		logic sda_d;
		vsw_state_e state;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [4:0] cfg;
		logic sda_oe;
		logic [2:0] lc;
		logic [1:0] rgbf;
	} vsw_top_s;

endpackage : vsw_pkg

// *** hw/vsw_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module vsw_sync #(
	parameter int WIDTH = 4
) (
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Pins and synchronised levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// Both stages, stage one only feeds stage two
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} vsw_sync_s;

	vsw_sync_s r_reg;
	vsw_sync_s r_next;

	// ----------------------------------------------------------------
	// Next state, two stages per bit
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		if (ce_in) begin
			r_next.s1 = async_in;
			r_next.s2 = r_reg.s1;
		end
	end

	// Reset to idle-high bus level so no false edge appears at release
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			r_reg <= '{s1: '1, s2: '1};
		end else begin
			r_reg <= r_next;
		end
	end

	assign sync_out = r_reg.s2;

endmodule : vsw_sync

// *** tb/vsw_master.sv ***
// Two-wire bus master model that drives the selector's link pins
`timescale 1ns/1ps
module vsw_master (
	// Clock and wire level
	input wire logic mclk_in,
	input wire logic sda_in,
	// Link pins, a one releases the line
	output logic scl_out,
	output logic sda_out
);
	// Idle bus, both lines left high
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	// Wait n falling edges, so pins move off the sampling edge
	task automatic w(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : w

	// Start or repeated start: data falls while clock is high
	task automatic go();
		w(2);
		sda_out = 1'b1;
		w(2);
		scl_out = 1'b1;
		w(4);
		sda_out = 1'b0;
		w(4);
		scl_out = 1'b0;
	endtask : go

	// Send n bits MSB first; a whole byte gets an acknowledge slot
	task automatic tx(input logic [7:0] d, input int n, output logic ack);
		ack = 1'b1;
		for (int i = 7; i > 7 - n; i--) begin
			w(2);
			sda_out = d[i];
			w(2);
			scl_out = 1'b1;
			w(4);
			scl_out = 1'b0;
		end
		// Release data so the receiver alone owns the ninth pulse
		if (n == 8) begin
			w(2);
			sda_out = 1'b1;
			w(2);
			scl_out = 1'b1;
			w(2);
			ack = sda_in;
			w(2);
			scl_out = 1'b0;
		end
	endtask : tx

	// Stop: data rises while clock is high, then bus left free
	task automatic halt();
		w(2);
		sda_out = 1'b0;
		w(2);
		scl_out = 1'b1;
		w(4);
		sda_out = 1'b1;
		w(8);
	endtask : halt
endmodule : vsw_master

// *** tb/vsw_top_tb.sv ***
// Self-checking bench of the video switch selector control
`timescale 1ns/1ps
`include "vsw_map.svh"
module vsw_top_tb;
	// ----------------------------------------------------------------
	// Pins, wire levels and counters
	// ----------------------------------------------------------------
	logic mclk = 1'b0; // System clock
	logic srst = 1'b1; // Reset held from time zero
	logic mode = 1'b0; // Serial mode first
	logic bank = 1'b0; // Bank pin
	logic d_scl = 1'b0; // Direct-mode clock pin level
	logic d_sda = 1'b0; // Direct-mode data pin level
	logic m_scl; // Master clock drive
	logic m_sda; // Master data drive
	logic oe; // Device pulls data low
	logic [2:0] lc; // Pair enables
	logic [1:0] rg; // Colour set enables
	logic ack; // Acknowledge seen by the master
	logic sdo; // Device data drive value
	int n_fail = 0; // Mismatches
	int checked = 0; // Comparisons
	int cyc = 0; // Cycles for the hang guard
	// Direct rows: {bank, data, clock, sets, pairs}
	logic [7:0] rows [8] = '{8'h00, 8'h21, 8'h42, 8'h64, 8'h88, 8'hb0, 8'hca, 8'hf4};
	// Pull-up on the open-drain data line
	wire logic scl_pin = mode ? d_scl : m_scl;
	wire logic sda_pin = mode ? d_sda : (m_sda & ~oe);

	vsw_top vsw_top_inst (.mclk_in(mclk), .srst_in(srst), .ce_in(1'b1),
		.interface_mode_select_in(mode), .bank_sel_in(bank), .scl_in(scl_pin),
		.sda_in(sda_pin), .sda_out(sdo), .sda_oe_out(oe),
		.luma_chroma_on_out(lc), .rgbf_set_on_out(rg));
	vsw_master vsw_master_inst (.mclk_in(mclk), .sda_in(sda_pin),
		.scl_out(m_scl), .sda_out(m_sda));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Switch outputs packed like the configuration byte
	function automatic logic [7:0] sw();
		return {3'h0, rg, lc};
	endfunction : sw

	// Address byte for a bank pin level and direction
	function automatic logic [7:0] ad(input logic b, input logic rw);
		return {`VSW_ADDR_HI, `VSW_ADDR_A1, ~b, rw};
	endfunction : ad

	// Start, address and one data byte, both acks compared
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic ak);
		vsw_master_inst.go();
		vsw_master_inst.tx(a, 8, ack);
		chk({7'h0, ack}, {7'h0, ak});
		vsw_master_inst.tx(d, 8, ack);
		chk({7'h0, ack}, {7'h0, ak});
	endtask : frame

	// Counts and verdict
	task automatic wrap_up();
		$display("counts checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Hang guard, far beyond the roughly 1400 cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		repeat (6) @(negedge mclk);
		chk(sw(), 8'h00);
		chk({7'h0, sdo}, 8'h00);
		$display("test reset done");
		// Direct control from the three pins, link pins as plain inputs
		mode = 1'b1;
		foreach (rows[i]) begin
			{bank, d_sda, d_scl} = rows[i][7:5];
			repeat (6) @(negedge mclk);
			chk(sw(), {3'h0, rows[i][4:0]});
		end
		$display("test direct done");
		// Back to serial: stored byte, still the reset value
		mode = 1'b0;
		bank = 1'b0;
		repeat (6) @(negedge mclk);
		chk(sw(), 8'h00);
		// Upper bits ignored, then a further byte updates again
		frame(ad(1'b0, 1'b0), 8'hff, 1'b0);
		chk(sw(), 8'h1f);
		vsw_master_inst.tx(8'h0a, 8, ack);
		chk({7'h0, ack}, 8'h00);
		chk(sw(), 8'h0a);
		vsw_master_inst.halt();
		repeat (100) @(negedge mclk);
		chk(sw(), 8'h0a);
		$display("test write done");
		// Stop after half a byte keeps the last whole byte
		vsw_master_inst.go();
		vsw_master_inst.tx(ad(1'b0, 1'b0), 8, ack);
		chk({7'h0, ack}, 8'h00);
		vsw_master_inst.tx(8'h15, 4, ack);
		vsw_master_inst.halt();
		chk(sw(), 8'h0a);
		$display("test partial done");
		// Read request is never answered
		frame(ad(1'b0, 1'b1), 8'h13, 1'b1);
		vsw_master_inst.halt();
		chk(sw(), 8'h0a);
		// Other bank address, then address bit one set, both refused
		bank = 1'b1;
		frame(ad(1'b0, 1'b0), 8'h13, 1'b1);
		vsw_master_inst.halt();
		chk(sw(), 8'h0a);
		frame({`VSW_ADDR_HI, ~`VSW_ADDR_A1, 1'b0, 1'b0}, 8'h13, 1'b1);
		vsw_master_inst.halt();
		chk(sw(), 8'h0a);
		$display("test refuse done");
		// Second bank address, repeated start between frames
		frame(ad(1'b1, 1'b0), 8'h11, 1'b0);
		chk(sw(), 8'h11);
		frame(ad(1'b1, 1'b0), 8'h04, 1'b0);
		vsw_master_inst.halt();
		chk(sw(), 8'h04);
		$display("test bank done");
		// Reset in mid-run clears every switch
		srst = 1'b1;
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		chk(sw(), 8'h00);
		repeat (3) @(negedge mclk);
		chk(sw(), 8'h00);
		$display("test rerun done");
		wrap_up();
	end
endmodule : vsw_top_tb
